// ==== inc/dac_load_consts.vh ====
// Constants for the serial load interface of a 16-bit converter front end.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef DAC_LOAD_CONSTS_VH
`define DAC_LOAD_CONSTS_VH

// ==========================================================
// Word format
`define WORD_BITS      16
`define COUNT_BITS     5
`define HOLD_RESET     16'h0000
`define SHIFT_RESET    16'h0000
`define COUNT_RESET    5'h00

// ==========================================================
// Buffering
`define FIFO_DEPTH     8
`define FIFO_AW        3

// ==========================================================
// Timing, least strobe low time in ns and cycle count at 4 ns clock
`define CLK_PERIOD_NS  4
`define STROBE_MIN_NS  30
`define STROBE_MIN_CYC ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== logic/dac_serial_load.v ====
// Serial load front end: samples the host's framed serial link, assembles
// 16-bit words and moves them to the converter holding register.
// Assumes all link pins are asynchronous to clock_in (250 MHz) and that the
// link clock is slow enough (25 MHz max) to be found by edge detection.
`timescale 1ns/1ps
`include "dac_load_consts.vh"
module dac_serial_load #(
   parameter WIDTH      = `WORD_BITS,
   parameter FIFO_DEPTH = `FIFO_DEPTH,
   parameter FIFO_AW    = `FIFO_AW
)
(
   input  wire             clock_in,
   input  wire             sys_rst_in,
   input  wire             chip_sel_n_in,
   input  wire             ser_clk_in,
   input  wire             ser_data_in,
   input  wire             holding_update_n_in,
   output reg  [WIDTH-1:0] hold_code_out,
   output reg              hold_update_out,
   output reg              word_drop_out
);

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_SHIFT = 2'h1;
   // Integer forms first, then cut on purpose to the counter widths
   localparam integer           FULL_COUNT_I = `WORD_BITS;
   localparam integer           STROBE_CYC_I = `STROBE_MIN_CYC;
   localparam [`COUNT_BITS-1:0] FULL_COUNT   = FULL_COUNT_I[`COUNT_BITS-1:0];
   localparam [3:0]             STROBE_CYC   = STROBE_CYC_I[3:0];

   // Synchroniser stages: first stage is read only by the second
   reg [1:0]  cs_meta;
   reg [1:0]  clk_meta;
   reg [1:0]  dat_meta;
   reg [1:0]  upd_meta;
   reg        cs_d;
   reg        clk_d;
   reg        upd_d;
   wire       cs_s;
   wire       clk_s;
   wire       dat_s;
   wire       upd_s;

   reg [1:0]             state;
   reg [WIDTH-1:0]       shift;
   reg [`COUNT_BITS-1:0] count;
   reg [WIDTH-1:0]       pend;
   reg                   pend_valid;
   reg [3:0]             low_cnt;

   wire clk_rise;
   wire cs_rise;
   wire cs_fall;
   wire strobe_held;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_ready;
   wire [WIDTH-1:0] fifo_out_data;

   assign cs_s  = cs_meta[1];
   assign clk_s = clk_meta[1];
   assign dat_s = dat_meta[1];
   assign upd_s = upd_meta[1];

   // ==========================================================
   // Input synchronisers and edge finders
   always @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         cs_meta  <= 2'h3;
         clk_meta <= 2'h0;
         dat_meta <= 2'h0;
         upd_meta <= 2'h3;
         cs_d     <= 1'b1;
         clk_d    <= 1'b0;
         upd_d    <= 1'b1;
      end
      else
      begin
         cs_meta  <= {cs_meta[0], chip_sel_n_in};
         clk_meta <= {clk_meta[0], ser_clk_in};
         dat_meta <= {dat_meta[0], ser_data_in};
         upd_meta <= {upd_meta[0], holding_update_n_in};
         cs_d     <= cs_s;
         clk_d    <= clk_s;
         upd_d    <= upd_s;
      end
   end

   assign clk_rise = clk_s && !clk_d;
   assign cs_rise  = cs_s && !cs_d;
   assign cs_fall  = !cs_s && cs_d;

   // ==========================================================
   // Frame and shift register
   // Data reaches clk_rise two cycles late, same as the clock, so setup holds
   always @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         state      <= ST_IDLE;
         shift      <= `SHIFT_RESET;
         count      <= `COUNT_RESET;
         pend       <= `SHIFT_RESET;
         pend_valid <= 1'b0;
         word_drop_out <= 1'b0;
      end
      else
      begin
         word_drop_out <= 1'b0;
         if (pend_valid && fifo_in_ready)
            pend_valid <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               // Link activity outside a frame is ignored
               if (cs_fall)
               begin
                  state <= ST_SHIFT;
                  count <= `COUNT_RESET;
               end
            end
            ST_SHIFT:
            begin
               if (cs_rise)
               begin
                  state <= ST_IDLE;
                  // Short or long frames are dropped, never half loaded
                  if (count == FULL_COUNT)
                  begin
                     if (!pend_valid || fifo_in_ready)
                     begin
                        pend       <= shift;
                        pend_valid <= 1'b1;
                     end
                     else
                        word_drop_out <= 1'b1;
                  end
                  else
                     word_drop_out <= 1'b1;
               end
               else if (clk_rise && !cs_s)
               begin
                  shift <= {shift[WIDTH-2:0], dat_s};
                  if (count != 5'h1F)
                     count <= count + 1'b1;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Word FIFO between the link and the holding register
   word_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clock_in      (clock_in),
      .sys_rst_in    (sys_rst_in),
      .in_valid_in   (pend_valid),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (pend),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready),
      .out_data_out  (fifo_out_data)
   );

   // ==========================================================
   // Strobe low-time filter; glitches shorter than the least width are ignored
   always @(posedge clock_in)
   begin
      if (sys_rst_in)
         low_cnt <= 4'h0;
      else if (upd_s)
         low_cnt <= 4'h0;
      else if (low_cnt != STROBE_CYC)
         low_cnt <= low_cnt + 1'b1;
   end

   assign strobe_held = (low_cnt == STROBE_CYC);

   // Drain: strobe low loads the oldest word; words wait while strobe is high
   // or chip select low, so a strobe tied low gives load at chip-select rise.
   assign fifo_out_ready = strobe_held && cs_s;

   // ==========================================================
   // Holding register, one full-word update per load
   always @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         hold_code_out   <= `HOLD_RESET;
         hold_update_out <= 1'b0;
      end
      else
      begin
         hold_update_out <= 1'b0;
         if (fifo_out_valid && fifo_out_ready)
         begin
            hold_code_out   <= fifo_out_data;
            hold_update_out <= 1'b1;
         end
      end
   end

endmodule

// ==== logic/word_fifo.v ====
// Synchronous FIFO holding assembled words before the holding register.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module word_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
)
(
   input  wire             clock_in,
   input  wire             sys_rst_in,
   input  wire             in_valid_in,
   output wire             in_ready_out,
   input  wire [WIDTH-1:0] in_data_in,
   output wire             out_valid_out,
   input  wire             out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      fill;
   wire            do_wr;
   wire            do_rd;

   // ==========================================================
   // Handshakes
   assign in_ready_out  = (fill != DEPTH[AW:0]);
   assign out_valid_out = (fill != {(AW+1){1'b0}});
   assign do_wr         = in_valid_in && in_ready_out;
   assign do_rd         = out_valid_out && out_ready_in;
   assign out_data_out  = mem[rd_ptr];

   // Storage needs no reset; pointers guard it
   always @(posedge clock_in)
   begin
      if (do_wr)
         mem[wr_ptr] <= in_data_in;
   end

   // Pointers and fill level
   always @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         fill   <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         if (do_wr && !do_rd)
            fill <= fill + 1'b1;
         else if (do_rd && !do_wr)
            fill <= fill - 1'b1;
      end
   end

endmodule

// ==== verif/dac_host_model.sv ====
// Host model: drives framed 16-bit words onto the serial link.
// Assumes callers start tasks on a bench clock falling edge.
`timescale 1ns/1ps
module dac_host_model
(
   output reg chip_sel_n_out,
   output reg ser_clk_out,
   output reg ser_data_out
);
   // Idle: deselected, link clock parked low
   initial
   begin
      chip_sel_n_out = 1'b1;
      ser_clk_out = 1'b0;
      ser_data_out = 1'b0;
   end
   // One frame of n bits, 64 ns period, 50% high share
   task send(input [15:0] w, input integer n);
      integer i;
      begin
         chip_sel_n_out = 1'b0;
         for (i = 0; i < n; i = i + 1)
         begin
            #17 ser_data_out = w[15 - (i % 16)];
            #15 ser_clk_out = 1'b1;
            #32 ser_clk_out = 1'b0;
         end
         #33 chip_sel_n_out = 1'b1;
         #3 ser_data_out = ~ser_data_out; // No stale level after release
         #64;
      end
   endtask
   // Clock and data activity while deselected
   task toggle(input integer n);
      repeat (n)
      begin
         #16 ser_clk_out = ~ser_clk_out;
         ser_data_out = ~ser_data_out;
      end
   endtask
endmodule

// ==== verif/dac_load_checker.sv ====
// Checker for the serial load front end, bound to its top module.
// Assumes two-flop synchronisers and an eight-cycle strobe filter.
`timescale 1ns/1ps
module dac_load_checker #(
   parameter WIDTH = 16
)
(
   input wire             clock_in,
   input wire             sys_rst_in,
   input wire             chip_sel_n_in,
   input wire             holding_update_n_in,
   input wire [WIDTH-1:0] hold_code_out,
   input wire             hold_update_out,
   input wire             word_drop_out
);
   // ==========
   // Properties
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   AST_RST_CLEAR: assert property ($fell(sys_rst_in) |->
      hold_code_out == 0 && !hold_update_out && !word_drop_out) else $error("not cleared");
   AST_HOLD_CAUSE: assert property (!$stable(hold_code_out) |-> hold_update_out)
      else $error("code moved silently");
   AST_DROP_PULSE: assert property (word_drop_out |=> !word_drop_out)
      else $error("drop pulse too long");
   AST_CS_LOW_NO_LOAD: assert property (!chip_sel_n_in [*4] |-> !hold_update_out)
      else $error("load in frame");
   AST_CS_LOW_NO_DROP: assert property (!chip_sel_n_in [*4] |-> !word_drop_out)
      else $error("drop in frame");
   AST_STROBE_HIGH: assert property (holding_update_n_in [*6] |-> !hold_update_out)
      else $error("load with strobe high");
   AST_STROBE_WIDTH: assert property (hold_update_out |-> !$past(holding_update_n_in, 8))
      else $error("strobe too short");
   AST_CS_RISE: assert property ($rose(chip_sel_n_in) && !holding_update_n_in |->
      ##[2:10] (hold_update_out || word_drop_out)) else $error("frame end lost");
endmodule
bind dac_serial_load dac_load_checker #(.WIDTH(WIDTH)) dac_load_checker_i (.clock_in,
   .sys_rst_in, .chip_sel_n_in, .holding_update_n_in, .hold_code_out, .hold_update_out,
   .word_drop_out);

// ==== verif/dac_serial_load_tb.sv ====
// Bench for the serial load front end with a host model.
// Assumes 250 MHz clock and strobe driven on falling edges.
`timescale 1ns/1ps
`include "dac_load_consts.vh"
module dac_serial_load_tb;
   reg         clock_in, sys_rst_in, holding_update_n_in;
   wire        cs_n, sclk, sdat, upd, drop;
   wire [15:0] hold;
   integer     failures, checks, upd_cnt, drop_cnt, i, u0, d0;
   reg  [31:0] seed;
   reg  [15:0] expv;
   reg  [15:0] q [0:9];
   // ==========
   // Instances
   dac_serial_load dac_serial_load_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .chip_sel_n_in(cs_n), .ser_clk_in(sclk), .ser_data_in(sdat),
      .holding_update_n_in(holding_update_n_in), .hold_code_out(hold),
      .hold_update_out(upd), .word_drop_out(drop));
   dac_host_model dac_host_model_i (.chip_sel_n_out(cs_n), .ser_clk_out(sclk),
      .ser_data_out(sdat));
   // Clock
   initial
   begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   // Pulse counters; cleared by reset so they have a single driver
   always @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         upd_cnt  <= 0;
         drop_cnt <= 0;
      end
      else
      begin
         upd_cnt  <= upd_cnt + upd;
         drop_cnt <= drop_cnt + drop;
      end
   end
   // ==========
   // Helpers
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // Only whole 16-bit frames replace the code
   function [15:0] exp_hold(input [15:0] p, input [15:0] w, input integer n);
      exp_hold = (n == 16) ? w : p;
   endfunction
   task chk(input [31:0] nm, input [15:0] e, input [15:0] g);
      begin
         checks = checks + 1;
         if (g !== e)
         begin
            failures = failures + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // Frame with strobe tied low, then code and pulse counts
   task frame(input [15:0] w, input integer n);
      begin
         u0 = upd_cnt;
         d0 = drop_cnt;
         dac_host_model_i.send(w, n);
         expv = exp_hold(expv, w, n);
         chk("hold", expv, hold);
         chk("cnt", {8'(n == 16), 8'(n != 16)}, {8'(upd_cnt - u0), 8'(drop_cnt - d0)});
      end
   endtask
   task print_verdict;
      begin
         if (failures == 0 && checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // ==========
   // Sequence
   initial
   begin
      failures = 0;
      checks = 0;
      seed = 32'h0000E0DD;
      expv = 16'h0000;
      sys_rst_in = 1'b1;
      holding_update_n_in = 1'b0;
      repeat (16) @(negedge clock_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge clock_in);
      chk("rst", 16'h0000, hold);
      for (i = 0; i < 12; i = i + 1)
      begin
         seed = xs(seed);
         frame(i == 0 ? 16'h8000 : i == 1 ? 16'h0001 : seed[15:0], 16);
      end
      frame(seed[31:16], 15);
      frame(seed[15:0], 17);
      dac_host_model_i.toggle(40);
      chk("idle", expv, hold);
      // Strobe high: queue until the buffer refuses
      holding_update_n_in = 1'b1;
      d0 = drop_cnt;
      for (i = 0; i < 10; i = i + 1)
      begin
         seed = xs(seed);
         q[i] = seed[15:0];
         dac_host_model_i.send(q[i], 16);
      end
      chk("hold", expv, hold);
      // Buffer plus pending slot keep DEPTH+1 words; the rest are dropped
      chk("full", 16'(10 - `FIFO_DEPTH - 1), 16'(drop_cnt - d0));
      // Strobe low drains the queue, last word stands
      u0 = upd_cnt;
      holding_update_n_in = 1'b0;
      repeat (40) @(negedge clock_in);
      chk("upd", 16'(`FIFO_DEPTH + 1), 16'(upd_cnt - u0));
      chk("hold", q[`FIFO_DEPTH], hold);
      print_verdict;
   end
   // Watchdog: several times the expected run of about 30 us
   initial
   begin
      #200000;
      failures = failures + 1;
      print_verdict;
   end
endmodule
